/* rtl/ebcs_sequencer.sv */
// Bus cycle sequencer for exception entry and special instructions
`timescale 1ns/1ps
`include "ebcs_params.svh"
module ebcs_sequencer (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic [2:0]        req_kind,
    input  wire logic              wake_recovery,
    input  wire logic [23:0]       vector_address,
    input  wire logic [23:0]       pc_value,
    input  wire logic [23:0]       stack_ptr,
    input  wire logic [15:0]       extended_control_reg,
    input  wire logic [23:0]       source_addr_reg,
    input  wire logic [23:0]       dest_addr_reg,
    input  wire logic [15:0]       transfer_count_word,
    input  wire logic              count_is_word,
    input  wire logic [2:0]        reg_count,
    input  wire logic              bus_ack,
    input  wire logic [15:0]       bus_rdata,
    output logic                   busy_ff,
    output logic                   done_ff,
    output logic [1:0]             cyc_ff,
    output logic                   byte_ff,
    output logic                   hold_ff,
    output logic [23:0]            addr_ff,
    output logic [15:0]            wdata_ff,
    output logic [23:0]            src_out_ff,
    output logic [23:0]            dst_out_ff,
    output logic [23:0]            handler_ff
);
    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        S_IDLE, S_PREF, S_INT1, S_STL, S_STH, S_STX, S_VEC, S_VEC2,
        S_INT2, S_HR1, S_HR2, S_BRD, S_BWR, S_MH, S_ML, S_END
    } ebcs_state_t;

    ebcs_state_t                    st_ff;
    logic [15:0]                    cnt_ff;
    logic [2:0]                     regs_ff;
    logic [23:0]                    sp_ff;
    logic [23:0]                    pc_ff;
    logic [15:0]                    hi_ff;

    function automatic logic [23:0] add24(input logic [23:0] a, input logic [23:0] b);
        add24 = a + b;
    endfunction

    // Issue a cycle: outputs change only when the previous one completed
    wire logic issued = (cyc_ff == ebcs_pkg::EBCS_CYC_INTERNAL)
                      || ((cyc_ff != ebcs_pkg::EBCS_CYC_NONE) && bus_ack);

    task automatic go(input ebcs_state_t s, input ebcs_pkg::ebcs_cyc_t c,
                      input logic [23:0] a, input logic [15:0] d, input logic h);
        st_ff    <= s;
        cyc_ff   <= c;
        addr_ff  <= a;
        wdata_ff <= d;
        hold_ff  <= h;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff      <= S_IDLE;
            cyc_ff     <= ebcs_pkg::EBCS_CYC_NONE;
            addr_ff    <= 24'h00_0000;
            wdata_ff   <= 16'h0000;
            hold_ff    <= 1'b0;
            byte_ff    <= 1'b0;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            cnt_ff     <= 16'h0000;
            regs_ff    <= 3'h0;
            sp_ff      <= 24'h00_0000;
            pc_ff      <= 24'h00_0000;
            hi_ff      <= 16'h0000;
            src_out_ff <= 24'h00_0000;
            dst_out_ff <= 24'h00_0000;
            handler_ff <= 24'h00_0000;
        end else begin
            done_ff <= 1'b0;
            unique case (st_ff)
                S_IDLE: begin
                    if (start) begin
                        busy_ff <= 1'b1;
                        sp_ff   <= stack_ptr;
                        pc_ff   <= pc_value;
                        byte_ff <= 1'b0;
                        unique case (ebcs_pkg::ebcs_req_t'(req_kind))
                            ebcs_pkg::EBCS_REQ_RESET:
                                go(S_VEC, ebcs_pkg::EBCS_CYC_READ, vector_address, 16'h0000,
                                   1'b1);
                            ebcs_pkg::EBCS_REQ_IRQ:
                                if (wake_recovery)
                                    go(S_PREF, ebcs_pkg::EBCS_CYC_INTERNAL, 24'h00_0000,
                                       16'h0000, 1'b0);
                                else
                                    go(S_PREF, ebcs_pkg::EBCS_CYC_READ,
                                       add24(pc_value, `EBCS_PF_STEP), 16'h0000,
                                       1'b0);
                            ebcs_pkg::EBCS_REQ_TRAP:
                                go(S_PREF, ebcs_pkg::EBCS_CYC_READ, pc_value, 16'h0000,
                                   1'b0);
                            ebcs_pkg::EBCS_REQ_BLOCK: begin
                                src_out_ff <= source_addr_reg;
                                dst_out_ff <= dest_addr_reg;
                                cnt_ff <= count_is_word ? transfer_count_word
                                                        : {8'h00, transfer_count_word[7:0]};
                                byte_ff <= 1'b1;
                                if ((count_is_word ? transfer_count_word
                                     : {8'h00, transfer_count_word[7:0]}) == 16'h0000)
                                    go(S_END, ebcs_pkg::EBCS_CYC_INTERNAL, 24'h00_0000,
                                       16'h0000, 1'b0);
                                else
                                    go(S_BRD, ebcs_pkg::EBCS_CYC_READ, source_addr_reg,
                                       16'h0000, 1'b0);
                            end
                            default: begin
                                regs_ff <= (reg_count < `EBCS_MIN_REGS) ? `EBCS_MIN_REGS :
                                           (reg_count > `EBCS_MAX_REGS) ? `EBCS_MAX_REGS
                                                                        : reg_count;
                                go(S_MH, ebcs_pkg::EBCS_CYC_WRITE,
                                   add24(stack_ptr, -`EBCS_STACK_STEP), 16'h0000, 1'b1);
                            end
                        endcase
                    end
                end
                S_END: begin
                    if (issued) begin
                        go(S_IDLE, ebcs_pkg::EBCS_CYC_NONE, addr_ff, 16'h0000, 1'b0);
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        byte_ff <= 1'b0;
                    end
                end
                default: begin
                    if (issued) begin
                        unique case (st_ff)
                            S_PREF: go(S_INT1, ebcs_pkg::EBCS_CYC_INTERNAL, addr_ff,
                                       16'h0000, 1'b0);
                            S_INT1: begin
                                sp_ff <= add24(sp_ff, -`EBCS_STACK_STEP);
                                go(S_STL, ebcs_pkg::EBCS_CYC_WRITE,
                                   add24(sp_ff, -`EBCS_STACK_STEP), pc_ff[15:0], 1'b0);
                            end
                            S_STL: begin
                                sp_ff <= add24(sp_ff, -`EBCS_STACK_STEP);
                                go(S_STH, ebcs_pkg::EBCS_CYC_WRITE,
                                   add24(sp_ff, -`EBCS_STACK_STEP), {8'h00, pc_ff[23:16]},
                                   1'b0);
                            end
                            S_STH: begin
                                sp_ff <= add24(sp_ff, -`EBCS_STACK_STEP);
                                go(S_STX, ebcs_pkg::EBCS_CYC_WRITE,
                                   add24(sp_ff, -`EBCS_STACK_STEP), extended_control_reg,
                                   1'b0);
                            end
                            S_STX: go(S_VEC, ebcs_pkg::EBCS_CYC_READ, vector_address,
                                      16'h0000, 1'b1);
                            S_VEC: begin
                                hi_ff <= bus_rdata;
                                go(S_VEC2, ebcs_pkg::EBCS_CYC_READ,
                                   add24(vector_address, `EBCS_VEC_STEP), 16'h0000, 1'b0);
                            end
                            S_VEC2: begin
                                handler_ff <= {hi_ff[7:0], bus_rdata};
                                go(S_INT2, ebcs_pkg::EBCS_CYC_INTERNAL, addr_ff,
                                   16'h0000, 1'b0);
                            end
                            S_INT2: go(S_HR1, ebcs_pkg::EBCS_CYC_READ, handler_ff,
                                       16'h0000, 1'b0);
                            S_HR1: go(S_HR2, ebcs_pkg::EBCS_CYC_READ,
                                      add24(handler_ff, `EBCS_PF_STEP), 16'h0000, 1'b0);
                            S_HR2: go(S_END, ebcs_pkg::EBCS_CYC_INTERNAL, addr_ff,
                                      16'h0000, 1'b0);
                            S_BRD: begin
                                go(S_BWR, ebcs_pkg::EBCS_CYC_WRITE, dst_out_ff,
                                   {8'h00, bus_rdata[7:0]}, 1'b0);
                            end
                            S_BWR: begin
                                src_out_ff <= add24(src_out_ff, `EBCS_XFER_STEP);
                                dst_out_ff <= add24(dst_out_ff, `EBCS_XFER_STEP);
                                cnt_ff <= cnt_ff - 16'h0001;
                                if (cnt_ff == 16'h0001)
                                    go(S_END, ebcs_pkg::EBCS_CYC_INTERNAL, addr_ff,
                                       16'h0000, 1'b0);
                                else
                                    go(S_BRD, ebcs_pkg::EBCS_CYC_READ,
                                       add24(src_out_ff, `EBCS_XFER_STEP), 16'h0000, 1'b0);
                            end
                            S_MH: go(S_ML, ebcs_pkg::EBCS_CYC_WRITE,
                                     add24(addr_ff, -`EBCS_STACK_STEP), 16'h0000, 1'b0);
                            S_ML: begin
                                regs_ff <= regs_ff - 3'h1;
                                if (regs_ff == 3'h1)
                                    go(S_END, ebcs_pkg::EBCS_CYC_INTERNAL, addr_ff,
                                       16'h0000, 1'b0);
                                else
                                    go(S_MH, ebcs_pkg::EBCS_CYC_WRITE,
                                       add24(addr_ff, -`EBCS_STACK_STEP), 16'h0000, 1'b1);
                            end
                            default: go(S_END, ebcs_pkg::EBCS_CYC_INTERNAL, addr_ff,
                                        16'h0000, 1'b0);
                        endcase
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_wake_no_read: assert property (@(posedge clock) disable iff (rst)
        (st_ff == S_IDLE && start && req_kind == 3'h1 && wake_recovery)
        |=> cyc_ff == ebcs_pkg::EBCS_CYC_INTERNAL) else $error("wake prefetch read");
    a_prefetch_addr: assert property (@(posedge clock) disable iff (rst)
        (st_ff == S_IDLE && start && req_kind == 3'h1 && !wake_recovery)
        |=> addr_ff == pc_value + 24'h00_0002 || addr_ff == $past(pc_value) + 24'h00_0002)
        else $error("bad prefetch addr");
    a_vec_hold: assert property (@(posedge clock) disable iff (rst)
        st_ff == S_VEC |-> hold_ff) else $error("vector not held");
    a_vec2_addr: assert property (@(posedge clock) disable iff (rst)
        st_ff == S_VEC2 |-> addr_ff == vector_address + 24'h00_0002) else $error("vec2 addr");
    a_zero_skip: assert property (@(posedge clock) disable iff (rst)
        (st_ff == S_IDLE && start && req_kind == 3'h3
         && (count_is_word ? transfer_count_word : {8'h00, transfer_count_word[7:0]}) == 16'h0000)
        |=> st_ff == S_END) else $error("zero count moved");
    a_step_src: assert property (@(posedge clock) disable iff (rst)
        (st_ff == S_BWR && issued) |=> src_out_ff == $past(src_out_ff) + 24'h00_0001)
        else $error("source step");
    a_stack_order: assert property (@(posedge clock) disable iff (rst)
        (st_ff == S_STL && issued) |=> st_ff == S_STH) else $error("stack order");
    a_int_after_vec: assert property (@(posedge clock) disable iff (rst)
        (st_ff == S_VEC2 && issued) |=> cyc_ff == ebcs_pkg::EBCS_CYC_INTERNAL)
        else $error("no internal state");
endmodule

/* rtl/ebcs_params.svh */
// Constants for the exception bus cycle sequencer
// What this block does
// - Reset entry reads vector, vector+2, one internal state, two handler reads.
// - Interrupt entry prefetch read, internal state, writes low, high, extended word.
// - After stacking read vector, vector+2, internal state, two handler reads.
// - Interrupt first read targets pushed program counter plus two.
// - Wake from sleep or standby replaces prefetch read with internal state.
// - Block transfer source from register five, destination from register six.
// - Both block transfer addresses increment by one per byte.
// - Byte count from count register; zero count gives no transfer cycles.
// - Multi-register stacking repeats access pair two, three or four times.
`ifndef EBCS_PARAMS_SVH
`define EBCS_PARAMS_SVH
`define EBCS_VEC_STEP     24'h00_0002
`define EBCS_PF_STEP      24'h00_0002
`define EBCS_XFER_STEP    24'h00_0001
`define EBCS_STACK_STEP   24'h00_0002
`define EBCS_MIN_REGS     3'h2
`define EBCS_MAX_REGS     3'h4
`endif

/* rtl/ebcs_pkg.sv */
// Types for the exception bus cycle sequencer
package ebcs_pkg;
    typedef enum logic [2:0] {
        EBCS_REQ_RESET,
        EBCS_REQ_IRQ,
        EBCS_REQ_TRAP,
        EBCS_REQ_BLOCK,
        EBCS_REQ_MULTI
    } ebcs_req_t;
    typedef enum logic [1:0] {
        EBCS_CYC_NONE,
        EBCS_CYC_READ,
        EBCS_CYC_WRITE,
        EBCS_CYC_INTERNAL
    } ebcs_cyc_t;
endpackage

/* testbench/ebcs_bus_model.sv */
// Memory and bus controller model answering the sequencer's bus cycles
`timescale 1ns/1ps
module ebcs_bus_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic [1:0]  cyc_ff,
    input  wire logic [23:0] addr_ff,
    output logic             bus_ack,
    output logic [15:0]      bus_rdata
);
    logic [1:0] wait_ff;
    logic       rw;
    assign rw = (cyc_ff == 2'h1) || (cyc_ff == 2'h2);
    // Data only valid while acknowledged; toggles otherwise so stale reads show
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_ack   <= 1'b0;
            wait_ff   <= 2'h0;
            bus_rdata <= 16'h0000;
        end else if (bus_ack) begin
            bus_ack   <= 1'b0;
            wait_ff   <= slow ? addr_ff[2:1] + 2'h1 : 2'h0;
            bus_rdata <= ~bus_rdata;
        end else if (rw && wait_ff == 2'h0) begin
            bus_ack   <= 1'b1;
            bus_rdata <= addr_ff[15:0] ^ 16'h5a5a;
        end else begin
            if (rw) begin
                wait_ff <= wait_ff - 2'h1;
            end
            bus_rdata <= ~bus_rdata;
        end
    end
endmodule

/* testbench/exception_bus_cycle_sequencer_tb.sv */
// Self-checking bench for the exception bus cycle sequencer
`timescale 1ns/1ps
module exception_bus_cycle_sequencer_tb;
    typedef struct packed {
        logic [1:0]  c;
        logic [23:0] a;
        logic [15:0] d;
        logic        dc;
        logic        hc;
    } ebcs_note_t;
    ebcs_note_t  notes[$];
    ebcs_note_t  nt;
    logic        clock = 0, rst = 1, start = 0, wake_recovery = 0, count_is_word = 0, slow = 0;
    logic [2:0]  req_kind = 3'h0, reg_count = 3'h2;
    logic [23:0] vector_address = 0, pc_value = 0, stack_ptr = 0, source_addr_reg = 0;
    logic [23:0] dest_addr_reg = 0, vec, pc, sp, src, dst, h, off;
    logic [15:0] extended_control_reg = 0, transfer_count_word = 0, wdata_ff, bus_rdata;
    logic        bus_ack, busy_ff, done_ff, byte_ff, hold_ff;
    logic [1:0]  cyc_ff;
    logic [23:0] addr_ff, src_out_ff, dst_out_ff, handler_ff;
    logic [7:0]  cnt;
    int          seed = 17, n_fail = 0, num_checks = 0, r, j;

    always #5 clock = ~clock;

    ebcs_sequencer u_dut (.clock, .rst, .start, .req_kind, .wake_recovery, .vector_address,
        .pc_value, .stack_ptr, .extended_control_reg, .source_addr_reg, .dest_addr_reg,
        .transfer_count_word, .count_is_word, .reg_count, .bus_ack, .bus_rdata, .busy_ff,
        .done_ff, .cyc_ff, .byte_ff, .hold_ff, .addr_ff, .wdata_ff, .src_out_ff, .dst_out_ff,
        .handler_ff);
    ebcs_bus_model u_mem (.clock, .rst, .slow, .cyc_ff, .addr_ff, .bus_ack, .bus_rdata);

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic report_and_stop;
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ex(input logic [1:0] c, input logic [23:0] a, input logic [15:0] d = 16'h0000,
                      input logic dc = 0, input logic hc = 0);
        notes.push_back('{c, a, d, dc, hc});
    endtask
    // Vector pair, internal, two handler reads, trailing internal
    task automatic tail;
        h = {vec[7:0] ^ 8'h5a, (vec[15:0] + 16'h0002) ^ 16'h5a5a};
        ex(2'h1, vec, 16'h0000, 0, 1);
        ex(2'h1, vec + 24'h00_0002);
        ex(2'h3, 0);
        ex(2'h1, h);
        ex(2'h1, h + 24'h00_0002);
        ex(2'h3, 0);
    endtask
    task automatic stack3;
        ex(2'h2, sp - 24'h00_0002, pc[15:0], 1);
        ex(2'h2, sp - 24'h00_0004, {8'h00, pc[23:16]}, 1);
        ex(2'h2, sp - 24'h00_0006, extended_control_reg, 1);
    endtask
    task automatic run(input logic [2:0] k);
        int i;
        @(negedge clock);
        req_kind = k;
        start = 1;
        @(negedge clock);
        start = 0;
        chk("busy", 24'h00_0001, {23'h0, busy_ff});
        chk("byte mode", {23'h0, k == 3'(ebcs_pkg::EBCS_REQ_BLOCK)}, {23'h0, byte_ff});
        for (i = 0; i < 400 && done_ff !== 1'b1; i++) @(negedge clock);
        if (done_ff !== 1'b1) begin
            n_fail++;
            report_and_stop;
        end
        chk("busy end", 24'h00_0000, {23'h0, busy_ff});
        chk("leftover cycles", 24'h00_0000, 24'(notes.size()));
    endtask

    // Takes the oldest note whenever a cycle completes
    always @(posedge clock) begin
        if (!rst && (cyc_ff == 2'h3 || (cyc_ff != 2'h0 && bus_ack === 1'b1))) begin
            if (notes.size() == 0) begin
                chk("spare cycle", 24'h00_0000, {22'h0, cyc_ff});
            end else begin
                nt = notes.pop_front();
                chk("cycle kind", {22'h0, nt.c}, {22'h0, cyc_ff});
                if (nt.c != 2'h3) chk("address", nt.a, addr_ff);
                if (nt.dc) chk("write data", {8'h00, nt.d}, {8'h00, wdata_ff});
                if (nt.hc) chk("bus hold", 24'h00_0001, {23'h0, hold_ff});
            end
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (4) @(negedge clock);
        rst = 0;
        for (r = 0; r < 3; r++) begin
            vec = 24'($random(seed)) & 24'hff_fffe;
            pc = 24'($random(seed)) & 24'hff_fffe;
            sp = (24'($random(seed)) & 24'hff_fffe) | 24'h00_1000;
            src = 24'($random(seed));
            dst = 24'($random(seed));
            slow = r[0];
            vector_address = vec;
            pc_value = pc;
            stack_ptr = sp;
            extended_control_reg = 16'($random(seed));
            tail();
            run(3'(ebcs_pkg::EBCS_REQ_RESET));
            chk("handler", h, handler_ff);
            wake_recovery = r[0];
            if (r[0]) ex(2'h3, 0); else ex(2'h1, pc + 24'h00_0002);
            ex(2'h3, 0);
            stack3();
            tail();
            run(3'(ebcs_pkg::EBCS_REQ_IRQ));
            chk("handler", h, handler_ff);
            ex(2'h1, pc);
            ex(2'h3, 0);
            stack3();
            tail();
            run(3'(ebcs_pkg::EBCS_REQ_TRAP));
            // Zero count gives one internal cycle only; byte mode ignores the high byte
            cnt = 8'(r * 2);
            count_is_word = r[0];
            transfer_count_word = r[0] ? {8'h00, cnt} : {8'h3c, cnt};
            source_addr_reg = src;
            dest_addr_reg = dst;
            for (j = 0; j < cnt; j++) begin
                ex(2'h1, src + 24'(j));
                ex(2'h2, dst + 24'(j), {8'h00, 8'(src + 24'(j)) ^ 8'h5a}, 1);
            end
            ex(2'h3, 0);
            run(3'(ebcs_pkg::EBCS_REQ_BLOCK));
            chk("source end", src + 24'(cnt), src_out_ff);
            chk("dest end", dst + 24'(cnt), dst_out_ff);
            reg_count = 3'(r + 2);
            off = 24'h00_0000;
            for (j = 0; j < 2 * (r + 2); j++) begin
                off = off + 24'h00_0002;
                ex(2'h2, sp - off, 16'h0000, 1, j[0] == 1'b0);
            end
            ex(2'h3, 0);
            run(3'(ebcs_pkg::EBCS_REQ_MULTI));
        end
        report_and_stop;
    end
endmodule
